/* include/rcs_defines.svh */
// Constants of the reset cause and status sequencer.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
`define RCS_CLK_MHZ        40
`define RCS_POWER_UP_DELAY_TIMER_TIME_US   72000
`define RCS_OST_CYCLES     1024
`define RCS_PC_W           13
`define RCS_DATA_W         8
`define RCS_ADDR_W         2
`define RCS_EV_W           4
`define RCS_SEEN_W         16
`define RCS_SYN_W          3
`define RCS_SYN_SUPPLY     0
`define RCS_SYN_PIN        1
`define RCS_SYN_WDT        2
`define RCS_SYN_INIT       3'h2
`define RCS_PC_RESET       13'h0000
`define RCS_PC_VECTOR      13'h0004
`define RCS_PC_STEP        13'h0001
`define RCS_ADDR_PRS       2'h0
`define RCS_ADDR_IRQ_STAT  2'h1
`define RCS_ADDR_IRQ_MASK  2'h2
`define RCS_ADDR_CORE_STAT 2'h3
`define RCS_PRS_BOR        0
`define RCS_PRS_POR        1
`define RCS_POR_FLAG_RST   1'b0
`define RCS_BOR_FLAG_RST   1'b1
`define RCS_CST_PD         0
`define RCS_CST_TO         1
`define RCS_CST_BOR        2
`define RCS_CST_POR        3
`define RCS_CST_RUN        4
`define RCS_EV_BOR         0
`define RCS_EV_EXT         1
`define RCS_EV_WDT         2
`define RCS_EV_WAKE        3
`define RCS_STI_POR_V      8'h18
`define RCS_STI_POR_K      8'h07
`define RCS_STI_EXT_RUN_V  8'h00
`define RCS_STI_EXT_RUN_K  8'h1f
`define RCS_STI_EXT_SLP_V  8'h10
`define RCS_STI_EXT_SLP_K  8'h07
`define RCS_STI_WDT_RST_V  8'h08
`define RCS_STI_WDT_RST_K  8'h07
`define RCS_STI_WDT_WAK_V  8'h00
`define RCS_STI_WAK_K      8'he7
`define RCS_STI_INT_WAK_V  8'h10
`endif

/* include/rcs_pkg.sv */
// Types of the reset cause and status sequencer.
`include "rcs_defines.svh"
package rcs_pkg;
  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_OSC,
    MEDIUM_CRYSTAL_OSC,
    HIGH_SPEED_CRYSTAL_OSC,
    RESISTOR_CAPACITOR_OSC
  } rcs_osc_t;
  typedef enum logic [2:0] {
    S_POWER_UP, S_BOR_HOLD, S_POWER_UP_DELAY_TIMER, S_OST, S_RELEASE, S_RUN, S_SLEEP
  } rcs_seq_t;
  typedef enum logic [1:0] {INIT_NONE, INIT_POWER_UP, INIT_RESET, INIT_WAKE} rcs_init_t;
  typedef struct packed {
    logic [`RCS_ADDR_W-1:0] addr;
    logic [`RCS_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } rcs_bus_req_t;
  typedef struct packed {
    rcs_osc_t oscMode;
    logic     power_up_delay_enable_n;
    logic     brownoutEnable;
  } rcs_cfg_t;
  typedef struct packed {
    logic                 load;
    logic [`RCS_PC_W-1:0] value;
  } rcs_pc_load_t;
  typedef struct packed {
    logic                   load;
    logic [`RCS_DATA_W-1:0] value;
    logic [`RCS_DATA_W-1:0] keep;
  } rcs_status_init_t;
  typedef struct packed {
    rcs_seq_t               seq;
    logic                   porFlagN;
    logic                   brownout_flag_n;
    logic                   watchdog_expiry_flag_n;
    logic                   sleep_entry_flag_n;
    logic [`RCS_EV_W-1:0]   irqStatus;
    logic [`RCS_EV_W-1:0]   irqMask;
    logic [`RCS_DATA_W-1:0] rdata;
    rcs_pc_load_t           pcLoad;
    rcs_status_init_t       statusInit;
    rcs_init_t              initClass;
    logic [`RCS_PC_W-1:0]   resumePc;
    logic                   pinPrev;
    logic                   wdtPrev;
    logic [`RCS_SEEN_W-1:0] ostSeen;
  } rcs_main_state_t;
endpackage : rcs_pkg

/* verification/rcs_source_model.sv */
// Behavioural reset sources: supply monitor, external reset pin and watchdog.
module rcs_source_model (
  // Clock.
  input  wire logic core_clk,
  // Source levels.
  output logic      supplyBelowTrip,
  output logic      external_reset_pin_n,
  output logic      watchdogTimeout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    supplyBelowTrip      = 1'b0;
    external_reset_pin_n = 1'b1;
    watchdogTimeout      = 1'b0;
  end
  // Holds one source active for n cycles, long enough to pass the synchronisers.
  task automatic pulse(input int which, input int n);
    @(posedge core_clk);
    case (which)
      0: supplyBelowTrip <= 1'b1;
      1: external_reset_pin_n <= 1'b0;
      default: watchdogTimeout <= 1'b1;
    endcase
    repeat (n) @(posedge core_clk);
    supplyBelowTrip      <= 1'b0;
    external_reset_pin_n <= 1'b1;
    watchdogTimeout      <= 1'b0;
  endtask : pulse
endmodule : rcs_source_model

/* verification/tb_top.sv */
// Self-checking testbench of the reset cause and status sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  localparam int POWER_UP_DELAY_TIMER = 20;
  localparam int OSC_STARTUP_TIMER  = 8;
  logic                 core_clk;
  logic                 rst_n;
  rcs_bus_req_t         busReq;
  logic [7:0]           busRdata;
  rcs_cfg_t             cfg;
  logic                 supplyBelowTrip;
  logic                 external_reset_pin_n;
  logic                 watchdogTimeout;
  logic                 sleepCmd;
  logic                 watchdogClear;
  logic                 global_irq_enable;
  logic                 irqFlagPending;
  logic [12:0]          pcCurrent;
  logic                 coreResetN;
  rcs_pc_load_t         pcLoad;
  rcs_status_init_t     statusInit;
  rcs_init_t            initClass;
  logic                 watchdog_expiry_flag_n;
  logic                 sleep_entry_flag_n;
  logic                 irqOut;
  rcs_status_init_t     lastSt;
  rcs_init_t            lastCls;
  logic [12:0]          lastPc;
  logic [7:0]           d;
  logic [3:0]           m;
  logic                 por, bor, to, pd;
  int                   lowCyc;
  int                   error_cnt;
  int                   num_checks;
  rcs_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER), .OST_CYCLES(OSC_STARTUP_TIMER)) rcs_sequencer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata), .cfg(cfg),
    .supplyBelowTrip(supplyBelowTrip), .external_reset_pin_n(external_reset_pin_n),
    .watchdogTimeout(watchdogTimeout), .sleepCmd(sleepCmd), .watchdogClear(watchdogClear),
    .global_irq_enable(global_irq_enable), .irqFlagPending(irqFlagPending), .pcCurrent(pcCurrent),
    .coreResetN(coreResetN), .pcLoad(pcLoad), .statusInit(statusInit), .initClass(initClass),
    .watchdog_expiry_flag_n(watchdog_expiry_flag_n), .sleep_entry_flag_n(sleep_entry_flag_n), .irqOut(irqOut));
  rcs_source_model rcs_source_model_inst (
    .core_clk(core_clk), .supplyBelowTrip(supplyBelowTrip),
    .external_reset_pin_n(external_reset_pin_n), .watchdogTimeout(watchdogTimeout));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (statusInit.load === 1'b1) begin
      lastSt  <= statusInit;
      lastCls <= initClass;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    busReq.addr  <= a;
    busReq.wdata <= v;
    busReq.wr    <= 1'b1;
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.rd   <= 1'b1;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 v = busRdata;
  endtask : rd
  task automatic pulseCore(input int which);
    @(posedge core_clk);
    if (which == 0) sleepCmd <= 1'b1;
    else watchdogClear <= 1'b1;
    @(posedge core_clk);
    sleepCmd      <= 1'b0;
    watchdogClear <= 1'b0;
  endtask : pulseCore
  task automatic waitLoad();
    lowCyc = 0;
    for (int i = 0; i < 500; i++) begin
      @(posedge core_clk);
      if (coreResetN === 1'b0) lowCyc++;
      if (pcLoad.load === 1'b1) begin
        lastPc = pcLoad.value;
        return;
      end
    end
    chk(1'b0, 1'b1);
  endtask : waitLoad
  // Compares the cause flags on the pins and in the read-only core status register.
  task automatic chkCause();
    chk({watchdog_expiry_flag_n, sleep_entry_flag_n}, {to, pd});
    rd(2'h3, d);
    chk(d, {3'h0, 1'b1, por, bor, to, pd});
  endtask : chkCause
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    busReq = '0;
    cfg = '{MEDIUM_CRYSTAL_OSC, 1'b0, 1'b1};
    sleepCmd = 1'b0;
    watchdogClear = 1'b0;
    global_irq_enable = 1'b1;
    irqFlagPending = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'hb3ed));
    pcCurrent = 13'($urandom);
    {por, bor, to, pd} = 4'b0111;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    waitLoad();
    chk(lowCyc >= POWER_UP_DELAY_TIMER + OSC_STARTUP_TIMER, 1);
    chk({lastPc, lastSt, lastCls}, {13'h0000, 1'b1, 8'h18, 8'h07, INIT_POWER_UP});
    rd(2'h0, d);
    chk(d, 8'h01);
    chkCause();
    wr(2'h3, 8'hff);
    chkCause();
    wr(2'h0, 8'h03);
    {por, bor} = 2'b11;
    rcs_source_model_inst.pulse(2, 4);
    waitLoad();
    to = 1'b0;
    chk({lastPc, lastSt, lastCls}, {13'h0000, 1'b1, 8'h08, 8'h07, INIT_RESET});
    chkCause();
    rd(2'h1, d);
    chk(d, 8'h04);
    m = 4'($urandom);
    wr(2'h2, {4'h0, m});
    #1 chk(irqOut, m[2]);
    wr(2'h1, 8'h04);
    #1 chk(irqOut, 1'b0);
    rcs_source_model_inst.pulse(1, 4);
    waitLoad();
    chk(lastPc, 13'h0000);
    chkCause();
    rd(2'h0, d);
    chk(d, 8'h03);
    pulseCore(1);
    pulseCore(0);
    repeat (5) @(posedge core_clk);
    irqFlagPending <= 1'b1;
    waitLoad();
    irqFlagPending <= 1'b0;
    {to, pd} = 2'b10;
    chk(lowCyc >= OSC_STARTUP_TIMER, 1);
    chk({lastPc, lastSt, lastCls}, {13'h0004, 1'b1, 8'h10, 8'he7, INIT_WAKE});
    chkCause();
    cfg.oscMode <= RESISTOR_CAPACITOR_OSC;
    global_irq_enable <= 1'b0;
    pulseCore(0);
    repeat (3) @(posedge core_clk);
    rcs_source_model_inst.pulse(2, 4);
    waitLoad();
    {to, pd} = 2'b00;
    chk(lowCyc < OSC_STARTUP_TIMER, 1);
    chk({lastPc, lastSt, lastCls}, {pcCurrent + 13'h0001, 1'b1, 8'h00, 8'he7, INIT_WAKE});
    chkCause();
    cfg.oscMode <= MEDIUM_CRYSTAL_OSC;
    rcs_source_model_inst.pulse(0, 5);
    repeat (4) @(posedge core_clk);
    rcs_source_model_inst.pulse(0, 3);
    waitLoad();
    {bor, to, pd} = 3'b011;
    chk(lowCyc >= POWER_UP_DELAY_TIMER + OSC_STARTUP_TIMER, 1);
    chk({lastPc, lastSt}, {13'h0000, 1'b1, 8'h18, 8'h07});
    rd(2'h0, d);
    chk(d, 8'h02);
    chkCause();
    @(posedge core_clk);
    cfg   <= '{RESISTOR_CAPACITOR_OSC, 1'b1, 1'b0};
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    {por, bor, to, pd} = 4'b0111;
    waitLoad();
    chk(lowCyc < OSC_STARTUP_TIMER, 1);
    chk({lastPc, lastSt, lastCls}, {13'h0000, 1'b1, 8'h18, 8'h07, INIT_POWER_UP});
    chkCause();
    rcs_source_model_inst.pulse(0, 5);
    repeat (3) @(posedge core_clk);
    chk(coreResetN, 1'b1);
    rd(2'h0, d);
    chk(d, 8'h01);
    final_report();
  end
  initial begin
    #(25ns * 20000);
    error_cnt++;
    final_report();
  end
endmodule : tb_top

/* verilog/rcs_down_counter.sv */
// Loadable synchronous down-counter that flags expiry.
module rcs_down_counter #(
  parameter int W = 16
) (
  // Clock and reset.
  input  logic         core_clk,
  input  logic         rst_n,
  // Control.
  input  logic         load,
  input  logic [W-1:0] loadValue,
  input  logic         enable,
  // Expiry.
  output logic         expired
);
  import rcs_pkg::*;
  typedef struct packed {
    logic [W-1:0] count;
  } rcs_cnt_state_t;
  rcs_cnt_state_t st;
  rcs_cnt_state_t next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = loadValue;
    end else if (enable && st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.count == '0;
endmodule : rcs_down_counter

/* verilog/rcs_sequencer.sv */
// Reset cause recorder, start-up delay sequencer and its register port.
`include "rcs_defines.svh"

module rcs_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = `RCS_POWER_UP_DELAY_TIMER_TIME_US * `RCS_CLK_MHZ,
  parameter int OST_CYCLES  = `RCS_OST_CYCLES
) (
  // Clock and power-on reset.
  input  logic                            core_clk,
  input  logic                            rst_n,
  // Register port.
  input  rcs_pkg::rcs_bus_req_t           busReq,
  output logic [`RCS_DATA_W-1:0]          busRdata,
  // Configuration word.
  input  rcs_pkg::rcs_cfg_t               cfg,
  // Reset sources, asynchronous.
  input  logic                            supplyBelowTrip,
  input  logic                            external_reset_pin_n,
  input  logic                            watchdogTimeout,
  // Processor core.
  input  logic                            sleepCmd,
  input  logic                            watchdogClear,
  input  logic                            global_irq_enable,
  input  logic                            irqFlagPending,
  input  logic [`RCS_PC_W-1:0]            pcCurrent,
  output logic                            coreResetN,
  output rcs_pkg::rcs_pc_load_t           pcLoad,
  output rcs_pkg::rcs_status_init_t       statusInit,
  output rcs_pkg::rcs_init_t              initClass,
  output logic                            watchdog_expiry_flag_n,
  output logic                            sleep_entry_flag_n,
  // Interrupt.
  output logic                            irqOut
);
  import rcs_pkg::*;

  localparam int POWER_UP_DELAY_TIMER_W = $clog2(POWER_UP_DELAY_TIMER_CYCLES + 1);
  localparam int OST_W  = $clog2(OST_CYCLES + 1);
  localparam logic [POWER_UP_DELAY_TIMER_W-1:0]      POWER_UP_DELAY_TIMER_LOAD = POWER_UP_DELAY_TIMER_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);
  localparam logic [OST_W-1:0]       OST_LOAD  = OST_W'(OST_CYCLES - 1);
  localparam logic [`RCS_SEEN_W-1:0] OST_LAST  = `RCS_SEEN_W'(OST_CYCLES - 1);

  localparam rcs_main_state_t RST_STATE = '{
    seq:                    S_POWER_UP,
    porFlagN:               `RCS_POR_FLAG_RST,
    brownout_flag_n:        `RCS_BOR_FLAG_RST,
    watchdog_expiry_flag_n: 1'b1,
    sleep_entry_flag_n:     1'b1,
    irqStatus:              '0,
    irqMask:                '0,
    rdata:                  '0,
    pcLoad:                 '0,
    statusInit:             '{load: 1'b1, value: `RCS_STI_POR_V, keep: `RCS_STI_POR_K},
    initClass:              INIT_POWER_UP,
    resumePc:               `RCS_PC_RESET,
    pinPrev:                1'b1,
    wdtPrev:                1'b0,
    ostSeen:                '0
  };

  rcs_main_state_t        st;
  rcs_main_state_t        next_st;
  logic [`RCS_SYN_W-1:0]  syncIn;
  logic [`RCS_SYN_W-1:0]  syncOut;
  logic                   pwrtLoad;
  logic                   pwrtDone;
  logic                   ostLoad;
  logic                   ostDone;
  logic                   crystal;
  logic                   brownLow;
  logic                   pinHigh;
  logic                   wdtEvent;
  logic                   pinFall;
  logic [`RCS_EV_W-1:0]   evSet;
  logic [`RCS_EV_W-1:0]   irqClr;
  logic [`RCS_DATA_W-1:0] readValue;

  function automatic rcs_status_init_t statusLoad(input logic [`RCS_DATA_W-1:0] v,
                                                  input logic [`RCS_DATA_W-1:0] k);
    statusLoad = '{load: 1'b1, value: v, keep: k};
  endfunction : statusLoad

  // Reset-source levels cross into the core clock domain here.
  assign syncIn[`RCS_SYN_SUPPLY] = supplyBelowTrip;
  assign syncIn[`RCS_SYN_PIN]    = external_reset_pin_n;
  assign syncIn[`RCS_SYN_WDT]    = watchdogTimeout;

  rcs_sync #(
    .W    (`RCS_SYN_W),
    .INIT (`RCS_SYN_INIT)
  ) uSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (syncIn),
    .syncOut  (syncOut)
  );

  rcs_down_counter #(
    .W (POWER_UP_DELAY_TIMER_W)
  ) uPowerUpDelay (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .load      (pwrtLoad),
    .loadValue (POWER_UP_DELAY_TIMER_LOAD),
    .enable    (st.seq == S_POWER_UP_DELAY_TIMER),
    .expired   (pwrtDone)
  );

  rcs_down_counter #(
    .W (OST_W)
  ) uOscStartup (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .load      (ostLoad),
    .loadValue (OST_LOAD),
    .enable    (st.seq == S_OST),
    .expired   (ostDone)
  );

  always_comb begin
    next_st   = st;
    pwrtLoad  = 1'b0;
    ostLoad   = 1'b0;
    evSet     = '0;
    readValue = '0;
    crystal   = cfg.oscMode != RESISTOR_CAPACITOR_OSC;
    brownLow  = cfg.brownoutEnable && syncOut[`RCS_SYN_SUPPLY];
    pinHigh   = syncOut[`RCS_SYN_PIN];
    wdtEvent  = syncOut[`RCS_SYN_WDT] && !st.wdtPrev;
    pinFall   = !pinHigh && st.pinPrev;
    next_st.pinPrev         = pinHigh;
    next_st.wdtPrev         = syncOut[`RCS_SYN_WDT];
    next_st.pcLoad.load     = 1'b0;
    next_st.statusInit.load = 1'b0;
    next_st.initClass       = INIT_NONE;
    next_st.ostSeen         = (st.seq == S_OST) ? st.ostSeen + 1'b1 : '0;

    // Software writes; hardware updates below take precedence.
    if (busReq.wr) begin
      case (busReq.addr)
        `RCS_ADDR_PRS: begin
          next_st.porFlagN        = busReq.wdata[`RCS_PRS_POR];
          next_st.brownout_flag_n = busReq.wdata[`RCS_PRS_BOR];
        end
        `RCS_ADDR_IRQ_MASK: begin
          next_st.irqMask = busReq.wdata[`RCS_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    case (st.seq)
      S_POWER_UP: begin
        if (!cfg.power_up_delay_enable_n) begin
          pwrtLoad    = 1'b1;
          next_st.seq = S_POWER_UP_DELAY_TIMER;
        end else if (crystal) begin
          ostLoad     = 1'b1;
          next_st.seq = S_OST;
        end else begin
          next_st.seq = S_RELEASE;
        end
      end
      S_BOR_HOLD: begin
        if (!brownLow) begin
          pwrtLoad    = 1'b1;
          next_st.seq = S_POWER_UP_DELAY_TIMER;
        end
      end
      S_POWER_UP_DELAY_TIMER: begin
        if (pwrtDone && crystal) begin
          ostLoad     = 1'b1;
          next_st.seq = S_OST;
        end else if (pwrtDone) begin
          next_st.seq = S_RELEASE;
        end
      end
      S_OST: begin
        if (ostDone) begin
          next_st.seq = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (pinHigh) begin
          next_st.seq          = S_RUN;
          next_st.pcLoad.load  = 1'b1;
          next_st.pcLoad.value = st.resumePc;
        end
      end
      S_RUN: begin
        if (wdtEvent) begin
          next_st.watchdog_expiry_flag_n = 1'b0;
          next_st.sleep_entry_flag_n     = 1'b1;
          evSet[`RCS_EV_WDT]             = 1'b1;
          next_st.initClass              = INIT_RESET;
          next_st.statusInit = statusLoad(`RCS_STI_WDT_RST_V, `RCS_STI_WDT_RST_K);
          next_st.resumePc   = `RCS_PC_RESET;
          next_st.seq        = S_RELEASE;
        end else if (pinFall) begin
          evSet[`RCS_EV_EXT] = 1'b1;
          next_st.initClass  = INIT_RESET;
          next_st.statusInit = statusLoad(`RCS_STI_EXT_RUN_V, `RCS_STI_EXT_RUN_K);
          next_st.resumePc   = `RCS_PC_RESET;
          next_st.seq        = S_RELEASE;
        end else if (sleepCmd) begin
          next_st.watchdog_expiry_flag_n = 1'b1;
          next_st.sleep_entry_flag_n     = 1'b0;
          next_st.seq                    = S_SLEEP;
        end else if (watchdogClear) begin
          next_st.watchdog_expiry_flag_n = 1'b1;
          next_st.sleep_entry_flag_n     = 1'b1;
        end
      end
      S_SLEEP: begin
        if (pinFall) begin
          next_st.watchdog_expiry_flag_n = 1'b1;
          next_st.sleep_entry_flag_n     = 1'b0;
          evSet[`RCS_EV_EXT]             = 1'b1;
          next_st.initClass              = INIT_RESET;
          next_st.statusInit = statusLoad(`RCS_STI_EXT_SLP_V, `RCS_STI_EXT_SLP_K);
          next_st.resumePc   = `RCS_PC_RESET;
          next_st.seq        = S_RELEASE;
        end else if (wdtEvent || irqFlagPending) begin
          next_st.watchdog_expiry_flag_n = !wdtEvent;
          next_st.sleep_entry_flag_n     = 1'b0;
          evSet[`RCS_EV_WAKE]            = 1'b1;
          next_st.initClass              = INIT_WAKE;
          next_st.statusInit = wdtEvent ? statusLoad(`RCS_STI_WDT_WAK_V, `RCS_STI_WAK_K)
                                        : statusLoad(`RCS_STI_INT_WAK_V, `RCS_STI_WAK_K);
          if (!wdtEvent && global_irq_enable) begin
            next_st.resumePc = `RCS_PC_VECTOR;
          end else begin
            next_st.resumePc = pcCurrent + `RCS_PC_STEP;
          end
          ostLoad     = crystal;
          next_st.seq = crystal ? S_OST : S_RELEASE;
        end
      end
      default: begin
        next_st.seq = S_POWER_UP;
      end
    endcase

    // A brown-out overrides every sequence step except S_POWER_UP and S_BOR_HOLD, including the power-up delay.
    if (brownLow && st.seq != S_BOR_HOLD && st.seq != S_POWER_UP) begin
      next_st.seq                    = S_BOR_HOLD;
      next_st.brownout_flag_n        = 1'b0;
      next_st.watchdog_expiry_flag_n = 1'b1;
      next_st.sleep_entry_flag_n     = 1'b1;
      next_st.pcLoad.load            = 1'b0;
      next_st.initClass              = INIT_POWER_UP;
      next_st.statusInit = statusLoad(`RCS_STI_POR_V, `RCS_STI_POR_K);
      next_st.resumePc   = `RCS_PC_RESET;
      evSet              = '0;
      evSet[`RCS_EV_BOR] = 1'b1;
      pwrtLoad           = 1'b0;
      ostLoad            = 1'b0;
    end

    // Sticky event bits: a new event wins over a write-one clear.
    irqClr = (busReq.wr && busReq.addr == `RCS_ADDR_IRQ_STAT) ? busReq.wdata[`RCS_EV_W-1:0] : '0;
    next_st.irqStatus = (st.irqStatus & ~irqClr) | evSet;

    case (busReq.addr)
      `RCS_ADDR_PRS: begin
        readValue[`RCS_PRS_POR] = st.porFlagN;
        readValue[`RCS_PRS_BOR] = st.brownout_flag_n;
      end
      `RCS_ADDR_IRQ_STAT: begin
        readValue[`RCS_EV_W-1:0] = st.irqStatus;
      end
      `RCS_ADDR_IRQ_MASK: begin
        readValue[`RCS_EV_W-1:0] = st.irqMask;
      end
      `RCS_ADDR_CORE_STAT: begin
        readValue[`RCS_CST_POR] = st.porFlagN;
        readValue[`RCS_CST_BOR] = st.brownout_flag_n;
        readValue[`RCS_CST_TO]  = st.watchdog_expiry_flag_n;
        readValue[`RCS_CST_PD]  = st.sleep_entry_flag_n;
        readValue[`RCS_CST_RUN] = st.seq == S_RUN;
      end
      default: begin
        readValue = '0;
      end
    endcase
    next_st.rdata = busReq.rd ? readValue : '0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign busRdata               = st.rdata;
  assign coreResetN             = st.seq == S_RUN || st.seq == S_SLEEP;
  assign pcLoad                 = st.pcLoad;
  assign statusInit             = st.statusInit;
  assign initClass              = st.initClass;
  assign watchdog_expiry_flag_n = st.watchdog_expiry_flag_n;
  assign sleep_entry_flag_n     = st.sleep_entry_flag_n;
  assign irqOut                 = |(st.irqStatus & st.irqMask);

  default clocking cbMain @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_por_flag_write: assert property (
    $changed(st.porFlagN) |-> $past(busReq.wr) && $past(busReq.addr) == `RCS_ADDR_PRS)
    else $error("power-on flag changed without a register write");

  chk_bor_entry_flags: assert property (
    st.seq != S_BOR_HOLD ##1 st.seq == S_BOR_HOLD |-> !st.brownout_flag_n && st.watchdog_expiry_flag_n
      && st.sleep_entry_flag_n && st.irqStatus[`RCS_EV_BOR])
    else $error("brown-out entry left wrong flags");

  chk_release_path: assert property (
    $rose(coreResetN) |-> $past(st.seq) == S_RELEASE && st.pcLoad.load)
    else $error("core reset released outside the release step");

  chk_ext_run_keep: assert property (
    st.seq == S_RUN && pinFall && !wdtEvent && !brownLow |=> $stable(st.watchdog_expiry_flag_n)
      && $stable(st.sleep_entry_flag_n) && st.statusInit.value == `RCS_STI_EXT_RUN_V)
    else $error("pin reset while running disturbed expiry or sleep flag");

  chk_sleep_pin_flags: assert property (
    st.seq == S_SLEEP && pinFall && !brownLow |=> st.watchdog_expiry_flag_n && !st.sleep_entry_flag_n
      && st.initClass == INIT_RESET)
    else $error("pin reset in sleep gave wrong flags");

  chk_wdt_reset_pc: assert property (
    st.seq == S_RUN && wdtEvent && !brownLow && pinHigh ##1 pinHigh && !brownLow
      |=> st.pcLoad.load && st.pcLoad.value == `RCS_PC_RESET && coreResetN)
    else $error("watchdog reset did not restart at zero");

  chk_irq_vector: assert property (
    st.seq == S_SLEEP && !pinFall && !wdtEvent && irqFlagPending && global_irq_enable && !brownLow
      |=> st.resumePc == `RCS_PC_VECTOR && st.initClass == INIT_WAKE && !st.sleep_entry_flag_n)
    else $error("interrupt wake did not select the vector");

  chk_ost_length: assert property (
    $past(st.seq) == S_OST && st.seq == S_RELEASE |-> $past(st.ostSeen) == OST_LAST)
    else $error("oscillator delay length wrong");

  chk_bor_restart: assert property (
    st.seq == S_POWER_UP_DELAY_TIMER && brownLow |=> st.seq == S_BOR_HOLD && !coreResetN)
    else $error("brown-out during power-up delay not restarted");

  chk_wdt_wake: assert property (
    st.seq == S_SLEEP && wdtEvent && !pinFall && !brownLow |=> st.initClass == INIT_WAKE
      && st.resumePc == $past(pcCurrent) + `RCS_PC_STEP && !st.watchdog_expiry_flag_n
      && st.statusInit.value == `RCS_STI_WDT_WAK_V)
    else $error("watchdog time-out in sleep not treated as wake-up");
endmodule : rcs_sequencer

/* verilog/rcs_sync.sv */
// Two-stage synchroniser for asynchronous reset-source levels.
module rcs_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset.
  input  logic         core_clk,
  input  logic         rst_n,
  // Levels.
  input  logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  import rcs_pkg::*;
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcs_sync_state_t;
  rcs_sync_state_t st;
  rcs_sync_state_t next_st;

  always_comb begin
    next_st.meta   = asyncIn;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '{meta: INIT, stable: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.stable;
endmodule : rcs_sync
